/* File: inc/ema_defines.svh */
`ifndef EMA_DEFINES_SVH
`define EMA_DEFINES_SVH

// Data memory address width; covers every data memory section directly.
`define EMA_ADDR_W 10
// Byte width of the datapath.
`define EMA_DATA_W 8
// Value written by the whole-byte set operation.
`define EMA_BYTE_ONES 8'hff
// Reset value of the accumulator.
`define EMA_ACC_RST 8'h00
// Reset value of the flag bits.
`define EMA_FLAGS_RST 6'h00
// Bit positions of the flags in the status word.
`define EMA_FLG_C 0
`define EMA_FLG_Z 1
`define EMA_FLG_AC 2
`define EMA_FLG_OV 3
`define EMA_FLG_SC 4
`define EMA_FLG_CZ 5
`define EMA_FLG_W 6

`endif

/* File: inc/ema_pkg.sv */
`default_nettype none
package ema_pkg;

  typedef enum logic [3:0] {
    EMA_ROTATE_RIGHT_MEM,
    EMA_ROTATE_RIGHT_TO_ACC,
    EMA_ROTATE_RIGHT_CARRY_MEM,
    EMA_ROTATE_RIGHT_CARRY_TO_ACC,
    EMA_SUBTRACT_BORROW_TO_ACC,
    EMA_SUBTRACT_BORROW_TO_MEM,
    EMA_SUBTRACT_TO_ACC,
    EMA_SUBTRACT_TO_MEM,
    EMA_DECREMENT_SKIP_ZERO,
    EMA_DECREMENT_SKIP_ZERO_ACC,
    EMA_INCREMENT_SKIP_ZERO,
    EMA_INCREMENT_SKIP_ZERO_ACC,
    EMA_SET_BYTE,
    EMA_SET_BIT,
    EMA_SKIP_IF_NONZERO,
    EMA_SKIP_IF_NONZERO_BIT
  } ema_op_t;

  // Field order matches the flag bit positions, carry in bit 0.
  typedef struct packed {
    logic chained_zero_flag;
    logic signed_result_flag;
    logic signed_wrap_flag;
    logic half_carry_flag;
    logic z;
    logic c;
  } ema_flags_t;

endpackage
`default_nettype wire

/* File: inc/ema_alu_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ema_alu_if;
  import ema_pkg::*;

  logic en;
  logic commit;
  ema_op_t op;
  logic [7:0] mem_byte;
  logic [7:0] acc;
  logic [2:0] bit_sel;
  logic st_wr;
  ema_flags_t st_wdata;
  ema_flags_t flags;
  logic [7:0] res;
  logic wr_mem;
  logic wr_acc;
  logic skip;
  logic upd_c;
  logic upd_arith;
  ema_flags_t new_flags;

  modport core (output en, commit, op, mem_byte, acc, bit_sel, st_wr,
                st_wdata, input flags, res, wr_mem, wr_acc, skip);
  modport alu (input op, mem_byte, acc, bit_sel, flags, output res,
               wr_mem, wr_acc, skip, upd_c, upd_arith, new_flags);
  modport flg (input en, commit, st_wr, st_wdata, upd_c, upd_arith,
               new_flags, output flags);
endinterface
`default_nettype wire

/* File: core/ema_alu.sv */
`timescale 1ns/100ps
`default_nettype none
module ema_alu (
  // Operands in, results out.
  ema_alu_if.alu x
);
  import ema_pkg::*;
  `include "ema_defines.svh"

  function automatic logic [8:0] ema_sub(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic bw);
    ema_sub = {1'b0, a} - {1'b0, b} - {8'h00, bw};
  endfunction

  function automatic logic ema_is_zero(input logic [7:0] v);
    ema_is_zero = (v == 8'h00);
  endfunction

  logic bw;
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic [7:0] dec_v;
  logic [7:0] inc_v;

  always_comb begin
    bw = 1'b0;
    if (x.op == EMA_SUBTRACT_BORROW_TO_ACC ||
        x.op == EMA_SUBTRACT_BORROW_TO_MEM) begin
      bw = ~x.flags.c;
    end
    diff = ema_sub(x.acc, x.mem_byte, bw);
    low_diff = {1'b0, x.acc[3:0]} - {1'b0, x.mem_byte[3:0]} - {4'h0, bw};
    dec_v = x.mem_byte - 8'h01;
    inc_v = x.mem_byte + 8'h01;
  end

  always_comb begin
    x.new_flags = x.flags;
    // Carry is set when no borrow left the byte.
    x.new_flags.c = ~diff[8];
    x.new_flags.z = ema_is_zero(diff[7:0]);
    x.new_flags.half_carry_flag = ~low_diff[4];
    x.new_flags.signed_wrap_flag = (x.acc[7] != x.mem_byte[7]) &&
                                   (diff[7] != x.acc[7]);
    x.new_flags.signed_result_flag = diff[7] ^ x.new_flags.signed_wrap_flag;
    x.new_flags.chained_zero_flag = ema_is_zero(diff[7:0]) &
                                    (~bw | x.flags.chained_zero_flag);
    x.res = x.mem_byte;
    x.wr_mem = 1'b0;
    x.wr_acc = 1'b0;
    x.skip = 1'b0;
    x.upd_c = 1'b0;
    x.upd_arith = 1'b0;
    case (x.op)
      EMA_ROTATE_RIGHT_MEM: begin
        x.res = {x.mem_byte[0], x.mem_byte[7:1]};
        x.wr_mem = 1'b1;
      end
      EMA_ROTATE_RIGHT_TO_ACC: begin
        x.res = {x.mem_byte[0], x.mem_byte[7:1]};
        x.wr_acc = 1'b1;
      end
      EMA_ROTATE_RIGHT_CARRY_MEM, EMA_ROTATE_RIGHT_CARRY_TO_ACC: begin
        x.res = {x.flags.c, x.mem_byte[7:1]};
        x.new_flags = x.flags;
        x.new_flags.c = x.mem_byte[0];
        x.upd_c = 1'b1;
        x.wr_mem = (x.op == EMA_ROTATE_RIGHT_CARRY_MEM);
        x.wr_acc = (x.op == EMA_ROTATE_RIGHT_CARRY_TO_ACC);
      end
      EMA_SUBTRACT_BORROW_TO_ACC, EMA_SUBTRACT_TO_ACC: begin
        x.res = diff[7:0];
        x.upd_arith = 1'b1;
        x.wr_acc = 1'b1;
      end
      EMA_SUBTRACT_BORROW_TO_MEM, EMA_SUBTRACT_TO_MEM: begin
        x.res = diff[7:0];
        x.upd_arith = 1'b1;
        x.wr_mem = 1'b1;
      end
      EMA_DECREMENT_SKIP_ZERO: begin
        x.res = dec_v;
        x.wr_mem = 1'b1;
        x.skip = ema_is_zero(dec_v);
      end
      EMA_DECREMENT_SKIP_ZERO_ACC: begin
        x.res = dec_v;
        x.wr_acc = 1'b1;
        x.skip = ema_is_zero(dec_v);
      end
      EMA_INCREMENT_SKIP_ZERO: begin
        x.res = inc_v;
        x.wr_mem = 1'b1;
        x.skip = ema_is_zero(inc_v);
      end
      EMA_INCREMENT_SKIP_ZERO_ACC: begin
        x.res = inc_v;
        x.wr_acc = 1'b1;
        x.skip = ema_is_zero(inc_v);
      end
      EMA_SET_BYTE: begin
        x.res = `EMA_BYTE_ONES;
        x.wr_mem = 1'b1;
      end
      EMA_SET_BIT: begin
        x.res = x.mem_byte | (8'h01 << x.bit_sel);
        x.wr_mem = 1'b1;
      end
      EMA_SKIP_IF_NONZERO: begin
        x.wr_mem = 1'b1;
        x.skip = ~ema_is_zero(x.mem_byte);
      end
      EMA_SKIP_IF_NONZERO_BIT: begin
        x.skip = x.mem_byte[x.bit_sel];
      end
      default: begin
        x.res = x.mem_byte;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: core/ema_flags.sv */
`timescale 1ns/100ps
`default_nettype none
module ema_flags (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Flag updates in, flags out.
  ema_alu_if.flg x
);
  import ema_pkg::*;
  `include "ema_defines.svh"

  ema_flags_t flags_ff;
  assign x.flags = flags_ff;

  // Only carry moves on a rotate through carry; all six move on a subtraction.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_ff <= `EMA_FLAGS_RST;
    end else if (x.en) begin
      if (x.st_wr) begin
        flags_ff <= x.st_wdata;
      end else if (x.commit && x.upd_arith) begin
        flags_ff <= x.new_flags;
      end else if (x.commit && x.upd_c) begin
        flags_ff.c <= x.new_flags.c;
      end
    end
  end
endmodule
`default_nettype wire

/* File: core/ema_top.sv */
// Operation
// - Rotate memory byte right, bit 0 into bit 7, write back, flags kept.
// - Accumulator rotate variants write only the accumulator, memory kept.
// - Rotate through carry: bit 0 to carry, old carry to bit 7.
// - Subtract with borrow: accumulator minus byte minus inverted carry.
// - Plain subtract: accumulator minus byte, to accumulator or memory.
// - After subtraction carry clears on negative, sets on zero or positive.
// - Subtractions update wrap, zero, half carry, carry, sign, chained zero.
// - Decrement byte, store back, skip next when zero, flags kept.
// - Accumulator decrement variant writes accumulator, skips on its zero.
// - Increment byte, store back, skip next when zero, flags kept.
// - Accumulator increment variant writes accumulator, skips on its zero.
// - A taken skip inserts a dummy cycle, three cycles in total.
// - An untaken skip continues with the following instruction.
// - Set byte writes all ones, flags kept.
// - Set bit forces only the selected bit to one, flags kept.
// - Bit test skips next when selected bit is one, flags kept.
// - Byte test writes byte back, skips when non-zero, flags kept.
// - Memory operand addressed directly over full range, no bank.
`timescale 1ns/100ps
`default_nettype none
`include "ema_defines.svh"
module ema_top #(
  parameter int ADDR_W = `EMA_ADDR_W
) (
  // Clock, reset and clock enable.
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // Instruction request from the decoder.
  input wire logic OP_VALID,
  output logic OP_READY,
  input wire ema_pkg::ema_op_t OP_CODE,
  input wire logic [ADDR_W-1:0] OP_ADDR,
  input wire logic [2:0] OP_BIT,
  // Instruction completion and skip indication.
  output logic OP_DONE,
  output logic DISCARD_NEXT,
  // Data memory port.
  output logic [ADDR_W-1:0] MEM_ADDR,
  output logic MEM_RD,
  input wire logic [7:0] MEM_RDATA,
  output logic MEM_WR,
  output logic [7:0] MEM_WDATA,
  // Accumulator and flag load from the core.
  input wire logic ACC_WR,
  input wire logic [7:0] ACC_WDATA,
  input wire logic FLAGS_WR,
  input wire ema_pkg::ema_flags_t FLAGS_WDATA,
  // Accumulator and flags.
  output logic [7:0] ACC,
  output ema_pkg::ema_flags_t FLAGS
);
  import ema_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_EXEC,
    ST_DUMMY
  } ema_state_t;

  ema_state_t state_ff;
  ema_state_t nxt_state;
  ema_op_t op_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [2:0] bit_ff;
  logic rd_ff;
  logic wr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] acc_ff;
  logic accept;
  logic exec;

  ema_alu_if x();

  ema_alu u_alu (
    .x(x)
  );

  ema_flags u_flags (
    .clk(CLK),
    .rst(RST),
    .x(x)
  );

  assign accept = CE && (state_ff == ST_IDLE) && OP_VALID;
  assign exec = CE && (state_ff == ST_EXEC);

  assign x.en = CE;
  assign x.commit = exec;
  assign x.op = op_ff;
  assign x.mem_byte = MEM_RDATA;
  assign x.acc = acc_ff;
  assign x.bit_sel = bit_ff;
  assign x.st_wr = FLAGS_WR && (state_ff == ST_IDLE);
  assign x.st_wdata = FLAGS_WDATA;

  assign OP_READY = (state_ff == ST_IDLE);
  assign OP_DONE = ((state_ff == ST_EXEC) && !x.skip) ||
                   (state_ff == ST_DUMMY);
  assign DISCARD_NEXT = (state_ff == ST_DUMMY);
  assign MEM_ADDR = addr_ff;
  assign MEM_RD = rd_ff;
  assign MEM_WR = wr_ff;
  assign MEM_WDATA = wdata_ff;
  assign ACC = acc_ff;
  assign FLAGS = x.flags;

  // Sequencer: read, execute, and a dummy slot when the skip is taken.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (OP_VALID) begin
          nxt_state = ST_READ;
        end
      end
      ST_READ: begin
        nxt_state = ST_EXEC;
      end
      ST_EXEC: begin
        if (x.skip) begin
          nxt_state = ST_DUMMY;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_DUMMY: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_ff <= ST_IDLE;
    end else if (CE) begin
      state_ff <= nxt_state;
    end
  end

  // Operand capture; the address is used as given over the full range.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      op_ff <= EMA_ROTATE_RIGHT_MEM;
      addr_ff <= '0;
      bit_ff <= 3'h0;
    end else if (accept) begin
      op_ff <= OP_CODE;
      addr_ff <= OP_ADDR;
      bit_ff <= OP_BIT;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rd_ff <= 1'b0;
    end else if (CE) begin
      rd_ff <= accept;
    end
  end

  // Memory write-back, issued in the cycle after execution.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end else if (CE) begin
      wr_ff <= exec && x.wr_mem;
      if (exec && x.wr_mem) begin
        wdata_ff <= x.res;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      acc_ff <= `EMA_ACC_RST;
    end else if (CE) begin
      if (exec && x.wr_acc) begin
        acc_ff <= x.res;
      end else if (ACC_WR && (state_ff == ST_IDLE)) begin
        acc_ff <= ACC_WDATA;
      end
    end
  end

  a_rot_mem_value: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_ROTATE_RIGHT_MEM) |=>
      MEM_WR && MEM_WDATA == {$past(MEM_RDATA[0]), $past(MEM_RDATA[7:1])}
      && FLAGS == $past(FLAGS))
    else $error("rotate right to memory wrong");

  a_acc_keeps_mem: assert property (@(posedge CLK) disable iff (RST)
    (exec && (op_ff == EMA_ROTATE_RIGHT_TO_ACC ||
              op_ff == EMA_ROTATE_RIGHT_CARRY_TO_ACC)) |=>
      !MEM_WR && ACC[6:0] == $past(MEM_RDATA[7:1]))
    else $error("accumulator rotate touched memory");

  a_rotc_ring: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_ROTATE_RIGHT_CARRY_TO_ACC) |=>
      FLAGS.c == $past(MEM_RDATA[0]) && ACC[7] == $past(FLAGS.c) &&
      FLAGS.z == $past(FLAGS.z))
    else $error("rotate through carry ring broken");

  a_sbc_value: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_SUBTRACT_BORROW_TO_ACC) |=>
      ACC == $past(ACC) - $past(MEM_RDATA) - {7'h00, ~$past(FLAGS.c)})
    else $error("subtract with borrow wrong");

  a_sub_mem_value: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_SUBTRACT_TO_MEM) |=>
      MEM_WR && MEM_WDATA == $past(ACC) - $past(MEM_RDATA))
    else $error("subtract to memory wrong");

  a_sub_carry: assert property (@(posedge CLK) disable iff (RST)
    (exec && (op_ff == EMA_SUBTRACT_TO_ACC || op_ff == EMA_SUBTRACT_TO_MEM))
      |=> FLAGS.c == ($past(ACC) >= $past(MEM_RDATA)))
    else $error("carry after subtract wrong");

  a_sub_zero_flag: assert property (@(posedge CLK) disable iff (RST)
    (exec && (op_ff == EMA_SUBTRACT_TO_ACC ||
              op_ff == EMA_SUBTRACT_BORROW_TO_ACC)) |=>
      FLAGS.z == (ACC == 8'h00) &&
      FLAGS.signed_result_flag == (ACC[7] ^ FLAGS.signed_wrap_flag))
    else $error("subtract flags wrong");

  a_dec_skip: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_DECREMENT_SKIP_ZERO) |=>
      MEM_WR && MEM_WDATA == $past(MEM_RDATA) - 8'h01 &&
      DISCARD_NEXT == (MEM_WDATA == 8'h00) && FLAGS == $past(FLAGS))
    else $error("decrement and skip wrong");

  a_dec_acc_skip: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_DECREMENT_SKIP_ZERO_ACC) |=>
      !MEM_WR && ACC == $past(MEM_RDATA) - 8'h01 &&
      DISCARD_NEXT == (ACC == 8'h00))
    else $error("accumulator decrement and skip wrong");

  a_inc_skip: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_INCREMENT_SKIP_ZERO) |=>
      MEM_WR && MEM_WDATA == $past(MEM_RDATA) + 8'h01 &&
      DISCARD_NEXT == (MEM_WDATA == 8'h00) && FLAGS == $past(FLAGS))
    else $error("increment and skip wrong");

  a_inc_acc_skip: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_INCREMENT_SKIP_ZERO_ACC) |=>
      !MEM_WR && ACC == $past(MEM_RDATA) + 8'h01 &&
      DISCARD_NEXT == (ACC == 8'h00))
    else $error("accumulator increment and skip wrong");

  a_skip_three_cyc: assert property (@(posedge CLK) disable iff (RST)
    (accept ##1 CE ##1 (CE && x.skip)) |=>
      DISCARD_NEXT && !OP_READY && OP_DONE)
    else $error("taken skip lacks dummy cycle");

  a_noskip_return: assert property (@(posedge CLK) disable iff (RST)
    (exec && !x.skip) |-> OP_DONE ##1 (OP_READY && !DISCARD_NEXT))
    else $error("untaken skip discarded next");

  a_set_byte: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_SET_BYTE) |=>
      MEM_WR && MEM_WDATA == `EMA_BYTE_ONES && FLAGS == $past(FLAGS))
    else $error("set byte wrong");

  a_set_bit: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_SET_BIT) |=>
      MEM_WR && MEM_WDATA == ($past(MEM_RDATA) | (8'h01 << $past(bit_ff)))
      && FLAGS == $past(FLAGS))
    else $error("set bit wrong");

  a_bit_test: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_SKIP_IF_NONZERO_BIT) |=>
      !MEM_WR && DISCARD_NEXT == $past(MEM_RDATA[bit_ff]) &&
      FLAGS == $past(FLAGS))
    else $error("bit test skip wrong");

  a_byte_test: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_SKIP_IF_NONZERO) |=>
      MEM_WR && MEM_WDATA == $past(MEM_RDATA) &&
      DISCARD_NEXT == ($past(MEM_RDATA) != 8'h00))
    else $error("byte test skip wrong");

  a_direct_addr: assert property (@(posedge CLK) disable iff (RST)
    accept |=> MEM_RD && MEM_ADDR == $past(OP_ADDR) ##1
      (MEM_ADDR == $past(MEM_ADDR) || !CE))
    else $error("operand address not held");

  a_rot_acc_value: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_ROTATE_RIGHT_TO_ACC) |=>
      ACC == {$past(MEM_RDATA[0]), $past(MEM_RDATA[7:1])} &&
      FLAGS == $past(FLAGS))
    else $error("rotate right to accumulator wrong");

  a_rotc_mem: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_ROTATE_RIGHT_CARRY_MEM) |=>
      MEM_WR && MEM_WDATA == {$past(FLAGS.c), $past(MEM_RDATA[7:1])} &&
      FLAGS.c == $past(MEM_RDATA[0]) && FLAGS[5:1] == $past(FLAGS[5:1]))
    else $error("rotate through carry to memory wrong");

  a_sbc_mem_value: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_SUBTRACT_BORROW_TO_MEM) |=>
      MEM_WR && ACC == $past(ACC) && MEM_WDATA ==
      $past(ACC) - $past(MEM_RDATA) - {7'h00, ~$past(FLAGS.c)})
    else $error("subtract with borrow to memory wrong");

  a_sub_acc_value: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_SUBTRACT_TO_ACC) |=>
      !MEM_WR && ACC == $past(ACC) - $past(MEM_RDATA))
    else $error("subtract to accumulator wrong");

  a_sbc_carry: assert property (@(posedge CLK) disable iff (RST)
    (exec && (op_ff == EMA_SUBTRACT_BORROW_TO_ACC ||
              op_ff == EMA_SUBTRACT_BORROW_TO_MEM)) |=>
      FLAGS.c == ({1'b0, $past(ACC)} >=
                  {1'b0, $past(MEM_RDATA)} + {8'h00, ~$past(FLAGS.c)}))
    else $error("carry after subtract with borrow wrong");

  a_sub_half_carry: assert property (@(posedge CLK) disable iff (RST)
    (exec && (op_ff == EMA_SUBTRACT_TO_ACC || op_ff == EMA_SUBTRACT_TO_MEM))
      |=> FLAGS.half_carry_flag ==
        ($past(ACC[3:0]) >= $past(MEM_RDATA[3:0])) &&
      FLAGS.chained_zero_flag == FLAGS.z)
    else $error("half carry after subtract wrong");

  a_sub_signed: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_SUBTRACT_TO_ACC) |=>
      FLAGS.signed_result_flag ==
        ($signed($past(ACC)) < $signed($past(MEM_RDATA))) &&
      FLAGS.signed_wrap_flag == (ACC[7] != FLAGS.signed_result_flag))
    else $error("signed flags after subtract wrong");

  a_set_bit_single: assert property (@(posedge CLK) disable iff (RST)
    (exec && op_ff == EMA_SET_BIT) |=>
      MEM_WDATA[$past(bit_ff)] &&
      $countones(MEM_WDATA ^ $past(MEM_RDATA)) <= 1)
    else $error("set bit touched other bits");

endmodule
`default_nettype wire

/* File: bench/ema_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
module ema_top_test;
  import ema_pkg::*;
  logic clk, rst, ce, op_valid, op_ready, op_done, discard_next;
  ema_op_t op_code;
  logic [9:0] op_addr, mem_addr;
  logic [2:0] op_bit;
  logic mem_rd, mem_wr, acc_wr, flags_wr;
  logic [7:0] mem_rdata, mem_wdata, acc_wdata, acc;
  ema_flags_t flags_wdata, flags;
  logic [7:0] mem [0:1023];
  int err_total, samples_checked, wr_cnt;

  ema_top ema_top_i (.CLK(clk), .RST(rst), .CE(ce), .OP_VALID(op_valid),
    .OP_READY(op_ready), .OP_CODE(op_code), .OP_ADDR(op_addr),
    .OP_BIT(op_bit), .OP_DONE(op_done), .DISCARD_NEXT(discard_next),
    .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata),
    .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .ACC_WR(acc_wr),
    .ACC_WDATA(acc_wdata), .FLAGS_WR(flags_wr),
    .FLAGS_WDATA(flags_wdata), .ACC(acc), .FLAGS(flags));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Data memory with one cycle of read latency.
  always @(posedge clk) begin
    if (ce && mem_rd) mem_rdata <= mem[mem_addr];
    if (ce && mem_wr) begin
      mem[mem_addr] <= mem_wdata;
      wr_cnt <= wr_cnt + 1;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic load(input logic [7:0] a, input ema_flags_t f);
    @(negedge clk);
    acc_wr = 1'b1;
    acc_wdata = a;
    flags_wr = 1'b1;
    flags_wdata = f;
    @(negedge clk);
    acc_wr = 1'b0;
    flags_wr = 1'b0;
  endtask

  // Issues one instruction and times its completion and skip.
  task automatic do_op(input ema_op_t op, input logic [9:0] a,
                       input logic [2:0] b, input logic sk_exp,
                       input int stall);
    int n;
    logic sk;
    @(negedge clk);
    chk(16'(op_ready), 16'h0001, "ready");
    op_valid = 1'b1;
    op_code = op;
    op_addr = a;
    op_bit = b;
    @(negedge clk);
    op_valid = 1'b0;
    chk({5'h00, mem_rd, mem_addr}, {5'h00, 1'b1, a}, "read addr");
    if (stall > 0) begin
      ce = 1'b0;
      repeat (stall) begin
        @(negedge clk);
        chk(16'(op_done), 16'h0000, "done frozen");
      end
      ce = 1'b1;
    end
    n = 1;
    sk = 1'b0;
    while (op_done !== 1'b1 && n < 6) begin
      @(negedge clk);
      n++;
      if (discard_next === 1'b1) sk = 1'b1;
    end
    chk(16'(n), sk_exp ? 16'h0003 : 16'h0002, "length");
    chk(16'(sk), 16'(sk_exp), "skip");
    @(negedge clk);
    chk(16'(discard_next), 16'h0000, "discard after");
    @(negedge clk);
  endtask

  task automatic t_rotate;
    mem[5] = 8'h81;
    mem[6] = 8'h03;
    load(8'h3c, 6'h2a);
    do_op(EMA_ROTATE_RIGHT_MEM, 10'h005, 3'h0, 1'b0, 0);
    chk(16'(mem[5]), 16'h00c0, "rotate mem");
    chk({acc, 2'b00, flags}, {8'h3c, 8'h2a}, "rotate kept");
    do_op(EMA_ROTATE_RIGHT_TO_ACC, 10'h006, 3'h0, 1'b0, 0);
    chk({acc, mem[6]}, {8'h81, 8'h03}, "rotate acc");
    chk(16'(flags), 16'h002a, "rotate acc flags");
  endtask

  task automatic t_rot_carry;
    mem[7] = 8'h02;
    mem[8] = 8'h01;
    load(8'h55, 6'h15);
    do_op(EMA_ROTATE_RIGHT_CARRY_MEM, 10'h007, 3'h0, 1'b0, 0);
    chk({mem[7], 2'b00, flags}, {8'h81, 8'h14}, "rrc mem");
    do_op(EMA_ROTATE_RIGHT_CARRY_TO_ACC, 10'h008, 3'h0, 1'b0, 0);
    chk({acc, 2'b00, flags}, {8'h00, 8'h15}, "rrc acc");
    chk(16'(mem[8]), 16'h0001, "rrc acc mem");
  endtask

  task automatic t_subtract;
    ema_op_t ops [5] = '{EMA_SUBTRACT_TO_ACC, EMA_SUBTRACT_TO_MEM,
      EMA_SUBTRACT_BORROW_TO_ACC, EMA_SUBTRACT_BORROW_TO_MEM,
      EMA_SUBTRACT_BORROW_TO_ACC};
    logic [7:0] av [5] = '{8'h05, 8'h03, 8'h80, 8'h10, 8'h11};
    logic [7:0] mv [5] = '{8'h05, 8'h05, 8'h01, 8'h10, 8'h10};
    logic [5:0] fv [5] = '{6'h00, 6'h3f, 6'h20, 6'h21, 6'h00};
    logic [8:0] full;
    logic [4:0] low;
    logic bw, tm, bor, z, ov;
    logic [9:0] a;
    ema_flags_t ef;
    for (int i = 0; i < 5; i++) begin
      a = 10'h010 + 10'(i);
      mem[a] = mv[i];
      bor = ops[i] inside {EMA_SUBTRACT_BORROW_TO_ACC,
                           EMA_SUBTRACT_BORROW_TO_MEM};
      tm = ops[i] inside {EMA_SUBTRACT_TO_MEM, EMA_SUBTRACT_BORROW_TO_MEM};
      bw = bor & ~fv[i][0];
      full = {1'b0, av[i]} - {1'b0, mv[i]} - 9'(bw);
      low = {1'b0, av[i][3:0]} - {1'b0, mv[i][3:0]} - 5'(bw);
      z = full[7:0] == 8'h00;
      ov = (av[i][7] ^ mv[i][7]) & (full[7] ^ av[i][7]);
      ef = {bor ? z & fv[i][5] : z, full[7] ^ ov, ov, ~low[4], z, ~full[8]};
      load(av[i], fv[i]);
      do_op(ops[i], a, 3'h0, 1'b0, i == 1 ? 3 : 0);
      chk(16'(tm ? mem[a] : acc), 16'(full[7:0]), "sub result");
      chk(16'(tm ? acc : mem[a]), 16'(tm ? av[i] : mv[i]), "sub other");
      chk(16'(flags.c), {15'h0000, ~full[8]}, "sub carry");
      chk(16'(flags), 16'(ef), "sub flags");
    end
  endtask

  task automatic t_step;
    ema_op_t ops [7] = '{EMA_DECREMENT_SKIP_ZERO, EMA_DECREMENT_SKIP_ZERO,
      EMA_DECREMENT_SKIP_ZERO_ACC, EMA_INCREMENT_SKIP_ZERO,
      EMA_INCREMENT_SKIP_ZERO, EMA_INCREMENT_SKIP_ZERO_ACC,
      EMA_DECREMENT_SKIP_ZERO_ACC};
    logic [7:0] mv [7] = '{8'h01, 8'h00, 8'h01, 8'hff, 8'h7f, 8'hff, 8'h05};
    logic [7:0] rv [7] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h80, 8'h00, 8'h04};
    logic [9:0] a;
    logic [7:0] ea;
    logic ta;
    ea = 8'h99;
    load(ea, 6'h2a);
    for (int i = 0; i < 7; i++) begin
      a = 10'h020 + 10'(i);
      mem[a] = mv[i];
      ta = ops[i] inside {EMA_DECREMENT_SKIP_ZERO_ACC,
                          EMA_INCREMENT_SKIP_ZERO_ACC};
      if (ta) ea = rv[i];
      do_op(ops[i], a, 3'h0, rv[i] == 8'h00, 0);
      chk({mem[a], acc}, {ta ? mv[i] : rv[i], ea}, "step");
      chk(16'(flags), 16'h002a, "step flags");
    end
  endtask

  task automatic t_bits;
    int w;
    load(8'h00, 6'h15);
    mem[10'h3ff] = 8'h12;
    mem[10'h1ff] = 8'h00;
    do_op(EMA_SET_BYTE, 10'h3ff, 3'h0, 1'b0, 0);
    chk({mem[10'h3ff], mem[10'h1ff]}, 16'hff00, "set byte");
    for (int i = 0; i < 8; i++) begin
      mem[10'h040 + 10'(i)] = 8'ha5;
      do_op(EMA_SET_BIT, 10'h040 + 10'(i), 3'(i), 1'b0, 0);
      chk(16'(mem[10'h040 + 10'(i)]), 16'(8'ha5 | (8'h01 << i)), "set bit");
    end
    mem[10'h050] = 8'h5a;
    w = wr_cnt;
    for (int i = 0; i < 8; i++)
      do_op(EMA_SKIP_IF_NONZERO_BIT, 10'h050, 3'(i), 1'(8'h5a >> i), 0);
    chk(16'(wr_cnt - w), 16'h0000, "bit test writes");
    mem[10'h051] = 8'h00;
    mem[10'h052] = 8'h40;
    do_op(EMA_SKIP_IF_NONZERO, 10'h051, 3'h0, 1'b0, 0);
    w = wr_cnt;
    do_op(EMA_SKIP_IF_NONZERO, 10'h052, 3'h0, 1'b1, 0);
    chk({mem[10'h052], 8'(wr_cnt - w)}, 16'h4001, "byte test");
    chk(16'(flags), 16'h0015, "bit flags");
  endtask

  initial begin
    #600000;
    err_total++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    op_valid = 1'b0;
    op_code = EMA_SET_BYTE;
    op_addr = 10'h000;
    op_bit = 3'h0;
    acc_wr = 1'b0;
    acc_wdata = 8'h00;
    flags_wr = 1'b0;
    flags_wdata = 6'h00;
    mem_rdata = 8'h00;
    wr_cnt = 0;
    for (int i = 0; i < 1024; i++) mem[i] = 8'h00;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk({op_ready, mem_wr, 6'h00, acc}, 16'h8000, "reset");
    chk(16'(flags), 16'h0000, "reset flags");
    t_rotate();
    t_rot_carry();
    t_subtract();
    t_step();
    t_bits();
    wrap_up();
  end
endmodule
`default_nettype wire
